// *** design/rst_defs.svh ***
`ifndef RST_DEFS_SVH
`define RST_DEFS_SVH
// Range setting encodings
`define RST_RANGE_IMAGE 2'h0
`define RST_RANGE_MEAS 2'h1
`define RST_RANGE_DISP 2'h2
// Reset values of the settings
`define RST_RANGE_RESET 2'h1
`define RST_INVERT_RESET 1'h0
`endif

// *** design/rst_pkg.sv ***
package rst_pkg;
  typedef enum logic [1:0] {
    RST_IDLE,
    RST_CAPTURE,
    RST_MEASURE,
    RST_DISPLAY
  } rst_phase_e;

  typedef struct packed {
    logic [2:0] sync;
    rst_phase_e phase;
    logic ready;
  } rst_state_s;

  typedef struct packed {
    logic [1:0] sync;
  } rst_sync_s;
endpackage

// *** design/rst_sync_if.sv ***
// Carries the synchronised start pulse to the sequencer
interface rst_sync_if;
  logic start_pulse;
  modport src (output start_pulse);
  modport dst (input start_pulse);
endinterface

// *** design/rst_sync.sv ***
`include "rst_defs.svh"
module rst_sync (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_in,
  rst_sync_if.src out
);
  rst_pkg::rst_sync_s st_reg;
  rst_pkg::rst_sync_s st_next;
  logic last_reg;

  // ------------------------------------------------------------
  // Two-flop synchroniser and rising edge detect
  // ------------------------------------------------------------
  always_comb begin
    st_next.sync = {st_reg.sync[0], pin_in};
  end

  // Second stage feeds the edge detector only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
      last_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      last_reg <= st_reg.sync[1];
    end
  end

  assign out.start_pulse = st_reg.sync[1] & ~last_reg;
endmodule

// *** design/rst_ready_timing.sv ***
`include "rst_defs.svh"
module rst_ready_timing (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic capture_start_input,
  input wire logic capture_done,
  input wire logic measure_done,
  input wire logic display_done,
  input wire logic [1:0] range_sel,
  input wire logic invert_sel,
  output logic enable_out,
  output logic cycle_busy
);
  rst_pkg::rst_state_s st_reg;
  rst_pkg::rst_state_s st_next;
  logic [1:0] range_reg;
  logic enable_reg;
  rst_sync_if sy ();

  // ------------------------------------------------------------
  // Start pin synchroniser
  // ------------------------------------------------------------
  rst_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(capture_start_input),
    .out(sy)
  );

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  // Completion point reached flag from next phase and range
  function automatic logic point_hit(input rst_pkg::rst_phase_e ph, input logic [1:0] rng);
    logic hit;
    hit = 1'b0;
    unique case (ph)
      rst_pkg::RST_IDLE: hit = 1'b1;
      rst_pkg::RST_CAPTURE: hit = 1'b0;
      rst_pkg::RST_MEASURE: hit = (rng == `RST_RANGE_IMAGE);
      rst_pkg::RST_DISPLAY: hit = (rng != `RST_RANGE_DISP);
    endcase
    return hit;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.sync = 3'h0;
    unique case (st_reg.phase)
      rst_pkg::RST_IDLE: begin
        if (sy.start_pulse) begin
          st_next.phase = rst_pkg::RST_CAPTURE;
        end
      end
      rst_pkg::RST_CAPTURE: begin
        if (capture_done) begin
          st_next.phase = rst_pkg::RST_MEASURE;
        end
      end
      rst_pkg::RST_MEASURE: begin
        if (measure_done) begin
          st_next.phase = (range_reg == `RST_RANGE_DISP) ? rst_pkg::RST_DISPLAY
                                                        : rst_pkg::RST_IDLE;
        end
      end
      rst_pkg::RST_DISPLAY: begin
        if (display_done) begin
          st_next.phase = rst_pkg::RST_IDLE;
        end
      end
    endcase
    st_next.ready = point_hit(st_next.phase, range_reg);
  end

  // Range latched only while idle so a cycle keeps one point
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '{sync: 3'h0, phase: rst_pkg::RST_IDLE, ready: 1'b1};
      range_reg <= `RST_RANGE_RESET;
      enable_reg <= ~`RST_INVERT_RESET;
    end else begin
      st_reg <= st_next;
      if (st_reg.phase == rst_pkg::RST_IDLE) begin
        range_reg <= (range_sel == 2'h3) ? `RST_RANGE_RESET : range_sel;
      end
      enable_reg <= st_next.ready ^ invert_sel;
    end
  end

  assign enable_out = enable_reg;
  assign cycle_busy = (st_reg.phase != rst_pkg::RST_IDLE);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_start;
    (st_reg.phase == rst_pkg::RST_IDLE) && sy.start_pulse;
  endsequence

  chk_start_drops: assert property (@(posedge clk_sys) disable iff (reset)
    s_start |=> (st_reg.ready == 1'b0))
    else $error("ready not cleared at cycle start");
  chk_image_point: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_CAPTURE && capture_done && range_reg == `RST_RANGE_IMAGE)
    |=> st_reg.ready)
    else $error("image point not ready");
  chk_meas_point: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_MEASURE && range_reg == `RST_RANGE_MEAS) |-> !st_reg.ready)
    else $error("ready before measurement end");
  chk_disp_point: assert property (@(posedge clk_sys) disable iff (reset)
    (range_reg == `RST_RANGE_DISP && st_reg.phase != rst_pkg::RST_IDLE) |-> !st_reg.ready)
    else $error("ready before display end");
  chk_norm_pol: assert property (@(posedge clk_sys) disable iff (reset)
    !invert_sel |=> (enable_out == st_reg.ready))
    else $error("normal polarity wrong");
  chk_inv_pol: assert property (@(posedge clk_sys) disable iff (reset)
    invert_sel |=> (enable_out == !st_reg.ready))
    else $error("inverted polarity wrong");
  chk_idle_ready: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_IDLE) |-> st_reg.ready)
    else $error("idle but not ready");
  chk_start_busy: assert property (@(posedge clk_sys) disable iff (reset)
    s_start |=> cycle_busy)
    else $error("start did not begin busy");

  // ------------------------------------------------------------
  // Phase step checks
  // ------------------------------------------------------------
  // Capture phase with its done seen
  sequence s_capture_end;
    (st_reg.phase == rst_pkg::RST_CAPTURE) && capture_done;
  endsequence

  // Measure phase with its done seen
  sequence s_measure_end;
    (st_reg.phase == rst_pkg::RST_MEASURE) && measure_done;
  endsequence

  // Display phase with its done seen
  sequence s_display_end;
    (st_reg.phase == rst_pkg::RST_DISPLAY) && display_done;
  endsequence

  // Idle stays idle until a start pulse
  chk_idle_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_IDLE) && !sy.start_pulse
    |=> (st_reg.phase == rst_pkg::RST_IDLE))
    else $error("cycle began without start");

  // One pin edge gives a single pulse
  chk_pulse_single: assert property (@(posedge clk_sys) disable iff (reset)
    sy.start_pulse
    |=> !sy.start_pulse)
    else $error("start pulse longer than one clock");

  // Capture waits for its done with enable held off
  chk_capture_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_CAPTURE) && !capture_done
    |=> (st_reg.phase == rst_pkg::RST_CAPTURE) && !st_reg.ready)
    else $error("capture left without done");

  // Capture end always moves on to measurement
  chk_capture_step: assert property (@(posedge clk_sys) disable iff (reset)
    s_capture_end
    |=> (st_reg.phase == rst_pkg::RST_MEASURE))
    else $error("capture end did not start measurement");

  // ------------------------------------------------------------
  // Cycle end checks
  // ------------------------------------------------------------
  // Measurement waits for its done and keeps its ready level
  chk_measure_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_MEASURE) && !measure_done
    |=> (st_reg.phase == rst_pkg::RST_MEASURE) && $stable(st_reg.ready))
    else $error("measurement left without done");

  // Measurement end frees the cycle unless display follows
  chk_measure_end: assert property (@(posedge clk_sys) disable iff (reset)
    s_measure_end ##0 (range_reg != `RST_RANGE_DISP)
    |=> st_reg.ready && !cycle_busy)
    else $error("measurement end did not free cycle");

  // Display point moves on to the display phase with ready low
  chk_measure_disp: assert property (@(posedge clk_sys) disable iff (reset)
    s_measure_end ##0 (range_reg == `RST_RANGE_DISP)
    |=> (st_reg.phase == rst_pkg::RST_DISPLAY) && !st_reg.ready)
    else $error("display phase not entered");

  // Display waits for its done with enable held off
  chk_display_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (st_reg.phase == rst_pkg::RST_DISPLAY) && !display_done
    |=> (st_reg.phase == rst_pkg::RST_DISPLAY) && !st_reg.ready)
    else $error("display left without done");

  // Display end frees the cycle
  chk_display_end: assert property (@(posedge clk_sys) disable iff (reset)
    s_display_end
    |=> st_reg.ready && !cycle_busy)
    else $error("display end did not free cycle");

  // Range cannot move under a running cycle
  chk_range_hold: assert property (@(posedge clk_sys) disable iff (reset)
    cycle_busy
    |=> $stable(range_reg))
    else $error("range changed during a cycle");

  // Pin shows the not ready level as busy begins
  chk_busy_enable: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(cycle_busy)
    |-> (enable_out == $past(invert_sel)))
    else $error("enable not dropped at busy start");
endmodule

// *** testbench/rst_ctrl_model.sv ***
// ----------------
// Controller model
// ----------------
module rst_ctrl_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic cycle_busy,
  output logic capture_start_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_reg = 3'h0;
  always_ff @(posedge clk_sys) begin
    if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    else if (go && !cycle_busy) hold_reg <= 3'h4;
  end
  // Pin is high while the pulse lasts
  assign capture_start_input = (hold_reg != 3'h0);
endmodule

// *** testbench/test_ready_signal_timing.sv ***
`include "rst_defs.svh"
// ----------------
// Ready timing bench
// ----------------
module test_ready_signal_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, reset = 1'h1, go = 1'h0, invert_sel = 1'h0;
  logic capture_start_input, enable_out, cycle_busy;
  logic [2:0] done_v = 3'h0;
  logic [1:0] range_sel = 2'h1;
  int bad_count = 0, check_count = 0, cyc = 0;
  // Clock, 8 ns period
  always #4 clk_sys = ~clk_sys;
  rst_ready_timing dut_u (.clk_sys(clk_sys), .reset(reset),
    .capture_start_input(capture_start_input), .capture_done(done_v[0]),
    .measure_done(done_v[1]), .display_done(done_v[2]), .range_sel(range_sel),
    .invert_sel(invert_sel), .enable_out(enable_out), .cycle_busy(cycle_busy));
  rst_ctrl_model ctrl_u (.clk_sys(clk_sys), .go(go), .cycle_busy(cycle_busy),
    .capture_start_input(capture_start_input));
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_sys);
    done_v <= m;
    @(posedge clk_sys);
    done_v <= 3'h0;
  endtask
  // One full cycle with a given range and polarity
  task automatic do_cycle(input logic [1:0] r, input logic i);
    int n;
    @(posedge clk_sys);
    range_sel <= r;
    invert_sel <= i;
    go <= 1'h1;
    n = 0;
    while (cycle_busy !== 1'h1 && n < 20) begin
      wait_n(1);
      n++;
    end
    @(posedge clk_sys);
    go <= 1'h0;
    wait_n(1);
    chk(enable_out, i);
    pulse(3'h2);
    wait_n(2);
    chk(enable_out, i);
    pulse(3'h1);
    wait_n(2);
    chk(enable_out, (r == `RST_RANGE_IMAGE) ? ~i : i);
    chk(cycle_busy, 1'h1);
    pulse(3'h2);
    wait_n(2);
    chk(enable_out, (r == `RST_RANGE_DISP) ? i : ~i);
    if (r == `RST_RANGE_DISP) begin
      pulse(3'h4);
      wait_n(2);
      chk(enable_out, ~i);
    end
    chk(cycle_busy, 1'h0);
  endtask
  task automatic test_image;
    do_cycle(`RST_RANGE_IMAGE, 1'h0);
  endtask
  task automatic test_meas;
    do_cycle(`RST_RANGE_MEAS, 1'h0);
    do_cycle(2'h3, 1'h0);
  endtask
  task automatic test_disp;
    do_cycle(`RST_RANGE_DISP, 1'h0);
  endtask
  task automatic test_invert;
    do_cycle(`RST_RANGE_MEAS, 1'h1);
    do_cycle(`RST_RANGE_IMAGE, 1'h1);
    chk(enable_out, 1'h0);
    @(posedge clk_sys);
    invert_sel <= 1'h0;
    wait_n(2);
    chk(enable_out, 1'h1);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'h0;
    wait_n(1);
    chk(enable_out, 1'h1);
    test_image();
    test_meas();
    test_disp();
    test_invert();
    end_sim();
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_sim();
    end
  end
endmodule
